// file: hw/charger_status_pkg.sv
// shared constants for the charger status readback block
package charger_status_pkg;

    // register offsets on the serial port
    localparam logic [7:0] INPUT_REGULATION_STATUS_OFFSET = 8'h1b;
    localparam logic [7:0] CHARGE_AND_INPUT_STATUS_OFFSET = 8'h1c;
    localparam logic [7:0] OPTIMIZER_THERMAL_DETECT_STATUS_OFFSET = 8'h1d;

    // reset value of every status register and of unmapped reads
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // field positions
    localparam int INPUT_RAIL_PRESENT_BIT = 0;
    localparam int CHARGE_PHASE_LSB = 5;
    localparam int ADAPTER_TYPE_LSB = 1;
    localparam int ADAPTER_DETECT_DONE_BIT = 0;
    localparam int OPTIMIZER_STATE_LSB = 6;
    localparam int THERMAL_REGULATION_BIT = 2;
    localparam int DATA_LINE_DETECT_BIT = 1;
    localparam int BATTERY_PRESENT_BIT = 0;

    typedef enum logic [2:0] {
        PHASE_IDLE = 3'b000,
        PHASE_TRICKLE = 3'b001,
        PHASE_PRECHARGE = 3'b010,
        PHASE_FAST_CC = 3'b011,
        PHASE_TAPER_CV = 3'b100,
        PHASE_RESERVED = 3'b101,
        PHASE_TOP_OFF = 3'b110,
        PHASE_DONE = 3'b111
    } charge_phase_e;

    typedef enum logic [3:0] {
        ADAPTER_NONE = 4'b0000,
        ADAPTER_SDP = 4'b0001,
        ADAPTER_CDP = 4'b0010,
        ADAPTER_DCP = 4'b0011,
        ADAPTER_HVDCP = 4'b0100,
        ADAPTER_UNKNOWN = 4'b0101,
        ADAPTER_NON_STANDARD = 4'b0110,
        ADAPTER_UNQUALIFIED = 4'b1000,
        ADAPTER_DIRECT_POWERED = 4'b1011
    } adapter_type_e;

    typedef enum logic [1:0] {
        OPTIMIZER_DISABLED = 2'b00,
        OPTIMIZER_RUNNING = 2'b01,
        OPTIMIZER_MAX_FOUND = 2'b10,
        OPTIMIZER_RESERVED = 2'b11
    } optimizer_state_e;

    // nominal input current per adapter, in mA
    localparam logic [11:0] CURRENT_NONE_MA = 12'h000;
    localparam logic [11:0] CURRENT_SDP_MA = 12'h1f4;
    localparam logic [11:0] CURRENT_CDP_MA = 12'h5dc;
    localparam logic [11:0] CURRENT_DCP_MA = 12'hcb2;
    localparam logic [11:0] CURRENT_HVDCP_MA = 12'h5dc;
    localparam logic [11:0] CURRENT_UNKNOWN_MA = 12'hbb8;
    localparam logic [11:0] CURRENT_NONSTD_1A_MA = 12'h3e8;
    localparam logic [11:0] CURRENT_NONSTD_2A_MA = 12'h7d0;
    localparam logic [11:0] CURRENT_NONSTD_2A1_MA = 12'h834;
    localparam logic [11:0] CURRENT_NONSTD_2A4_MA = 12'h960;

    // serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
    localparam logic [6:0] DEFAULT_DEVICE_ADDR = 7'h2a;

endpackage

// file: hw/charger_status_readback.sv
// serial-port status readback of the charger, with live status capture
//
// Notes on behaviour
// R1 - status bit 0 shows input rail present
// R2 - bits 7-5 report the charge phase
// R3 - bits 4-1 report the detected adapter type
// R4 - adapter code implies a nominal input current
// R5 - bit 0 set once adapter detection completes
// R6 - bits 7-6 report current optimizer state
// R7 - bit 2 high during thermal regulation
// R8 - bit 1 high only while data-line detection runs
// R9 - bit 0 high when battery above release level
// R10 - charge/input status at 1Ch, read-only, reset zero
// R11 - optimizer status at 1Dh, bits 5-3 zero
// R12 - fields track live conditions, writes are ignored
`timescale 1ns/1ps
module charger_status_readback #(
    // arbitrary neutral bus address
    parameter logic [6:0] DEVICE_ADDR = charger_status_pkg::DEFAULT_DEVICE_ADDR
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_scl_in,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_input_rail_present,
    input wire logic [2:0] i_charge_phase,
    input wire logic [3:0] i_adapter_type,
    input wire logic i_adapter_detect_done,
    input wire logic [1:0] i_input_current_optimizer_state,
    input wire logic i_thermal_regulation_active,
    input wire logic i_data_line_detect_active,
    input wire logic i_battery_above_release_level,
    input wire logic [1:0] i_nonstd_current_sel,
    output logic [11:0] o_nominal_input_current_ma
);

    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0000,
        BUS_ADDR = 4'b0001,
        BUS_ADDR_ACK = 4'b0010,
        BUS_POINTER = 4'b0011,
        BUS_POINTER_ACK = 4'b0100,
        BUS_WRITE_DATA = 4'b0101,
        BUS_WRITE_ACK = 4'b0110,
        BUS_READ_DATA = 4'b0111,
        BUS_READ_ACK = 4'b1000
    } bus_state_e;

    logic [1:0] pins_sync;
    logic scl;
    logic sda;
    logic scl_prev;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    bus_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] pointer;
    logic read_mode;
    logic master_nack;
    logic [7:0] input_regulation_status;
    logic [7:0] charge_and_input_status;
    logic [7:0] optimizer_thermal_detect_status;
    logic [7:0] read_byte;

    pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_scl_in, i_sda_in}),
        .o_sync(pins_sync)
    );

    assign scl = pins_sync[1];
    assign sda = pins_sync[0];

    status_capture u_status_capture (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_input_rail_present(i_input_rail_present),
        .i_charge_phase(i_charge_phase),
        .i_adapter_type(i_adapter_type),
        .i_adapter_detect_done(i_adapter_detect_done),
        .i_input_current_optimizer_state(i_input_current_optimizer_state),
        .i_thermal_regulation_active(i_thermal_regulation_active),
        .i_data_line_detect_active(i_data_line_detect_active),
        .i_battery_above_release_level(i_battery_above_release_level),
        .i_nonstd_current_sel(i_nonstd_current_sel),
        .o_input_regulation_status(input_regulation_status),
        .o_charge_and_input_status(charge_and_input_status),
        .o_optimizer_thermal_detect_status(optimizer_thermal_detect_status),
        .o_nominal_input_current_ma(o_nominal_input_current_ma)
    );

    // unmapped offsets read as zero
    function automatic logic [7:0] read_register(input logic [7:0] offset);
        logic [7:0] value;
        value = charger_status_pkg::STATUS_RESET;
        unique case (offset)
            charger_status_pkg::INPUT_REGULATION_STATUS_OFFSET: value = input_regulation_status;
            charger_status_pkg::CHARGE_AND_INPUT_STATUS_OFFSET: value = charge_and_input_status; // R10
            charger_status_pkg::OPTIMIZER_THERMAL_DETECT_STATUS_OFFSET:
                value = optimizer_thermal_detect_status; // R11
            default: value = charger_status_pkg::STATUS_RESET;
        endcase
        return value;
    endfunction

    always_comb read_byte = read_register(pointer);

    // edge detection looks only at the second synchroniser stage
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl;
            sda_prev <= sda;
        end
    end

    assign scl_rise = scl & ~scl_prev;
    assign scl_fall = ~scl & scl_prev;
    assign start_seen = scl & scl_prev & sda_prev & ~sda;
    assign stop_seen = scl & scl_prev & ~sda_prev & sda;

    // receive side: data is sampled on the rising clock edge
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_shift <= charger_status_pkg::STATUS_RESET;
            master_nack <= 1'b0;
        end else if (scl_rise) begin
            if (state == BUS_ADDR || state == BUS_POINTER || state == BUS_WRITE_DATA) begin
                rx_shift <= {rx_shift[6:0], sda};
            end
            if (state == BUS_READ_ACK) begin
                master_nack <= sda;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_cnt <= 4'h0;
        end else if (start_seen || stop_seen) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && (state == BUS_ADDR || state == BUS_POINTER || state == BUS_WRITE_DATA)) begin
            bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_fall) begin
            unique case (state)
                BUS_ADDR_ACK, BUS_POINTER_ACK, BUS_WRITE_ACK, BUS_READ_ACK: bit_cnt <= 4'h0;
                BUS_READ_DATA: bit_cnt <= bit_cnt + 4'h1;
                default: bit_cnt <= bit_cnt;
            endcase
        end
    end

    // protocol sequencing and pin drive happen on the falling clock edge,
    // so the data line only moves while the clock is low
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= BUS_IDLE;
            read_mode <= 1'b0;
            o_sda_oe <= 1'b0;
            tx_shift <= charger_status_pkg::STATUS_RESET;
        end else if (start_seen) begin
            // repeated start keeps the pointer so a read follows a pointer write
            state <= BUS_ADDR;
            o_sda_oe <= 1'b0;
        end else if (stop_seen) begin
            state <= BUS_IDLE;
            o_sda_oe <= 1'b0;
        end else if (scl_fall) begin
            unique case (state)
                BUS_IDLE: begin
                    o_sda_oe <= 1'b0;
                end
                BUS_ADDR: begin
                    if (bit_cnt == charger_status_pkg::BITS_PER_BYTE) begin
                        if (rx_shift[7:1] == DEVICE_ADDR) begin
                            read_mode <= rx_shift[0];
                            o_sda_oe <= 1'b1;
                            state <= BUS_ADDR_ACK;
                        end else begin
                            state <= BUS_IDLE;
                        end
                    end
                end
                BUS_ADDR_ACK: begin
                    if (read_mode) begin
                        // byte is snapshotted whole so a live change cannot tear it
                        tx_shift <= read_byte;
                        o_sda_oe <= ~read_byte[7];
                        state <= BUS_READ_DATA;
                    end else begin
                        o_sda_oe <= 1'b0;
                        state <= BUS_POINTER;
                    end
                end
                BUS_POINTER: begin
                    if (bit_cnt == charger_status_pkg::BITS_PER_BYTE) begin
                        o_sda_oe <= 1'b1;
                        state <= BUS_POINTER_ACK;
                    end
                end
                BUS_POINTER_ACK: begin
                    o_sda_oe <= 1'b0;
                    state <= BUS_WRITE_DATA;
                end
                BUS_WRITE_DATA: begin
                    // data bytes are acknowledged but never stored
                    if (bit_cnt == charger_status_pkg::BITS_PER_BYTE) begin
                        o_sda_oe <= 1'b1; // R12
                        state <= BUS_WRITE_ACK;
                    end
                end
                BUS_WRITE_ACK: begin
                    o_sda_oe <= 1'b0;
                    state <= BUS_WRITE_DATA;
                end
                BUS_READ_DATA: begin
                    if (bit_cnt[2:0] == charger_status_pkg::LAST_BIT_INDEX) begin
                        o_sda_oe <= 1'b0;
                        state <= BUS_READ_ACK;
                    end else begin
                        tx_shift <= {tx_shift[6:0], 1'b0};
                        o_sda_oe <= ~tx_shift[6];
                    end
                end
                BUS_READ_ACK: begin
                    if (master_nack) begin
                        o_sda_oe <= 1'b0;
                        state <= BUS_IDLE;
                    end else begin
                        tx_shift <= read_byte;
                        o_sda_oe <= ~read_byte[7];
                        state <= BUS_READ_DATA;
                    end
                end
            endcase
        end
    end

    // register pointer: loaded by the first written byte, bumped after each read byte
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pointer <= charger_status_pkg::STATUS_RESET;
        end else if (scl_fall && state == BUS_POINTER && bit_cnt == charger_status_pkg::BITS_PER_BYTE) begin
            pointer <= rx_shift;
        end else if (scl_fall && state == BUS_READ_DATA && bit_cnt[2:0] == charger_status_pkg::LAST_BIT_INDEX) begin
            pointer <= pointer + 8'h01;
        end
    end

    // open-drain pin: only ever pulls low
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sda_out <= 1'b0;
        end else begin
            o_sda_out <= 1'b0;
        end
    end

endmodule // charger_status_readback

// file: hw/pin_sync.sv
// two flip-flop synchroniser for the serial pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1;

    // idle bus level is high, so reset to ones to avoid a false start
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1 <= '1;
            o_sync <= '1;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule // pin_sync

// file: hw/status_capture.sv
// live capture of charger conditions into the status registers
`timescale 1ns/1ps
module status_capture (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_input_rail_present,
    input wire logic [2:0] i_charge_phase,
    input wire logic [3:0] i_adapter_type,
    input wire logic i_adapter_detect_done,
    input wire logic [1:0] i_input_current_optimizer_state,
    input wire logic i_thermal_regulation_active,
    input wire logic i_data_line_detect_active,
    input wire logic i_battery_above_release_level,
    input wire logic [1:0] i_nonstd_current_sel,
    output logic [7:0] o_input_regulation_status,
    output logic [7:0] o_charge_and_input_status,
    output logic [7:0] o_optimizer_thermal_detect_status,
    output logic [11:0] o_nominal_input_current_ma
);

    function automatic logic [11:0] nominal_current(input logic [3:0] code, input logic [1:0] sel);
        logic [11:0] value;
        value = charger_status_pkg::CURRENT_NONE_MA;
        unique case (code)
            charger_status_pkg::ADAPTER_SDP: value = charger_status_pkg::CURRENT_SDP_MA;
            charger_status_pkg::ADAPTER_CDP: value = charger_status_pkg::CURRENT_CDP_MA;
            charger_status_pkg::ADAPTER_DCP: value = charger_status_pkg::CURRENT_DCP_MA;
            charger_status_pkg::ADAPTER_HVDCP: value = charger_status_pkg::CURRENT_HVDCP_MA;
            charger_status_pkg::ADAPTER_UNKNOWN: value = charger_status_pkg::CURRENT_UNKNOWN_MA;
            charger_status_pkg::ADAPTER_NON_STANDARD: begin
                unique case (sel)
                    2'h0: value = charger_status_pkg::CURRENT_NONSTD_1A_MA;
                    2'h1: value = charger_status_pkg::CURRENT_NONSTD_2A_MA;
                    2'h2: value = charger_status_pkg::CURRENT_NONSTD_2A1_MA;
                    2'h3: value = charger_status_pkg::CURRENT_NONSTD_2A4_MA;
                endcase
            end
            // unqualified, direct powered and reserved codes imply no figure
            default: value = charger_status_pkg::CURRENT_NONE_MA;
        endcase
        return value;
    endfunction

    // only the rail-present bit of this register is kept here
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_input_regulation_status <= charger_status_pkg::STATUS_RESET;
        end else begin
            o_input_regulation_status <= charger_status_pkg::STATUS_RESET;
            o_input_regulation_status[charger_status_pkg::INPUT_RAIL_PRESENT_BIT] <= i_input_rail_present; // R1
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_charge_and_input_status <= charger_status_pkg::STATUS_RESET; // R10
        end else begin
            o_charge_and_input_status[charger_status_pkg::CHARGE_PHASE_LSB +: 3] <= i_charge_phase; // R2
            o_charge_and_input_status[charger_status_pkg::ADAPTER_TYPE_LSB +: 4] <= i_adapter_type; // R3
            o_charge_and_input_status[charger_status_pkg::ADAPTER_DETECT_DONE_BIT] <= i_adapter_detect_done; // R5
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_optimizer_thermal_detect_status <= charger_status_pkg::STATUS_RESET; // R11
        end else begin
            o_optimizer_thermal_detect_status <= charger_status_pkg::STATUS_RESET; // R11
            o_optimizer_thermal_detect_status[charger_status_pkg::OPTIMIZER_STATE_LSB +: 2] <=
                i_input_current_optimizer_state; // R6
            o_optimizer_thermal_detect_status[charger_status_pkg::THERMAL_REGULATION_BIT] <=
                i_thermal_regulation_active; // R7
            o_optimizer_thermal_detect_status[charger_status_pkg::DATA_LINE_DETECT_BIT] <=
                i_data_line_detect_active; // R8
            o_optimizer_thermal_detect_status[charger_status_pkg::BATTERY_PRESENT_BIT] <=
                i_battery_above_release_level; // R9
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_nominal_input_current_ma <= charger_status_pkg::CURRENT_NONE_MA;
        end else begin
            o_nominal_input_current_ma <= nominal_current(i_adapter_type, i_nonstd_current_sel); // R4
        end
    end

endmodule // status_capture

// file: sim/charger_status_readback_asserts.sv
// concurrent checks on the ports of the charger status readback block
`timescale 1ns/1ps
module charger_status_readback_asserts (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_scl_in,
    input wire logic i_sda_in,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic i_input_rail_present,
    input wire logic [2:0] i_charge_phase,
    input wire logic [3:0] i_adapter_type,
    input wire logic i_adapter_detect_done,
    input wire logic [1:0] i_input_current_optimizer_state,
    input wire logic i_thermal_regulation_active,
    input wire logic i_data_line_detect_active,
    input wire logic i_battery_above_release_level,
    input wire logic [1:0] i_nonstd_current_sel,
    input wire logic [11:0] o_nominal_input_current_ma
);
    wire logic [11:0] cur_ma = o_nominal_input_current_ma;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    function automatic logic [11:0] nonstd_ma(logic [1:0] s);
        case (s)
            2'h0: return charger_status_pkg::CURRENT_NONSTD_1A_MA;
            2'h1: return charger_status_pkg::CURRENT_NONSTD_2A_MA;
            2'h2: return charger_status_pkg::CURRENT_NONSTD_2A1_MA;
            default: return charger_status_pkg::CURRENT_NONSTD_2A4_MA;
        endcase
    endfunction
    sequence adapter_is(logic [3:0] code);
        i_adapter_type == code;
    endsequence
    sdp_current_a: assert property (adapter_is(4'h1) |=> cur_ma == charger_status_pkg::CURRENT_SDP_MA)
        else $error("sdp current wrong");
    cdp_current_a: assert property (adapter_is(4'h2) |=> cur_ma == charger_status_pkg::CURRENT_CDP_MA)
        else $error("cdp current wrong");
    dcp_current_a: assert property (adapter_is(4'h3) |=> cur_ma == charger_status_pkg::CURRENT_DCP_MA)
        else $error("dcp current wrong");
    hvdcp_current_a: assert property (adapter_is(4'h4) |=> cur_ma == charger_status_pkg::CURRENT_HVDCP_MA)
        else $error("hvdcp current wrong");
    unknown_current_a: assert property (adapter_is(4'h5) |=> cur_ma == charger_status_pkg::CURRENT_UNKNOWN_MA)
        else $error("unknown adapter current wrong");
    nonstd_current_a: assert property (adapter_is(4'h6) |=> cur_ma == nonstd_ma($past(i_nonstd_current_sel)))
        else $error("non-standard current wrong");
    other_current_a: assert property ((i_adapter_type == 4'h0 || i_adapter_type > 4'h6) |=> cur_ma == 12'h000)
        else $error("current not zero for this code");
    // data may only move while the serial clock is low, never mid high phase
    oe_edge_a: assert property ($changed(o_sda_oe) |-> !i_scl_in && !$past(i_scl_in, 2))
        else $error("data pin changed while clock high");
    oe_stands_a: assert property ($rose(i_scl_in) |-> $stable(o_sda_oe) [*6])
        else $error("data pin not held through clock high");
endmodule // charger_status_readback_asserts
bind charger_status_readback charger_status_readback_asserts chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_scl_in(i_scl_in), .i_sda_in(i_sda_in), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .i_input_rail_present(i_input_rail_present), .i_charge_phase(i_charge_phase), .i_adapter_type(i_adapter_type),
    .i_adapter_detect_done(i_adapter_detect_done), .i_input_current_optimizer_state(i_input_current_optimizer_state),
    .i_thermal_regulation_active(i_thermal_regulation_active), .i_data_line_detect_active(i_data_line_detect_active),
    .i_battery_above_release_level(i_battery_above_release_level), .i_nonstd_current_sel(i_nonstd_current_sel),
    .o_nominal_input_current_ma(o_nominal_input_current_ma));

// file: sim/host_i2c_model.sv
// behavioural serial host that reads the status registers
`timescale 1ns/1ps
module host_i2c_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    output logic o_scl,
    output logic o_sda_pull,
    input wire logic i_sda
);
    // 400 ns bit time keeps both clock phases well above the 5-cycle minimum
    localparam int HALF = 200;
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    task automatic start();
        #(HALF/2) o_sda_pull = 1'b0;
        #(HALF/2) o_scl = 1'b1;
        #HALF o_sda_pull = 1'b1;
        #HALF o_scl = 1'b0;
    endtask
    task automatic stop();
        #(HALF/2) o_sda_pull = 1'b1;
        #(HALF/2) o_scl = 1'b1;
        #HALF o_sda_pull = 1'b0;
        #HALF;
    endtask
    // data set mid low phase, sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        #(HALF/2) o_sda_pull = !b;
        #(HALF/2) o_scl = 1'b1;
        #HALF r = i_sda;
        o_scl = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(last, a);
        ack = !a;
    endtask
    task automatic read2(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1, output logic ok);
        logic [7:0] x;
        logic a0, a1, a2, n;
        start();
        byte_io({ADDR, 1'b0}, 1'b1, x, a0);
        byte_io(ptr, 1'b1, x, a1);
        start();
        byte_io({ADDR, 1'b1}, 1'b1, x, a2);
        byte_io(8'hff, 1'b0, d0, n);
        byte_io(8'hff, 1'b1, d1, n);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic write1(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
        logic [7:0] x;
        logic a0, a1, a2;
        start();
        byte_io({ADDR, 1'b0}, 1'b1, x, a0);
        byte_io(ptr, 1'b1, x, a1);
        byte_io(data, 1'b1, x, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic probe(input logic [6:0] addr, output logic ok);
        logic [7:0] x;
        start();
        byte_io({addr, 1'b0}, 1'b1, x, ok);
        stop();
    endtask
endmodule // host_i2c_model

// file: sim/tb.sv
// self-checking bench for the charger status readback block
`timescale 1ns/1ps
module tb;
    localparam logic [6:0] DEV = 7'h2a;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [15:0] st = 16'h0000;
    logic [31:0] v;
    logic [7:0] d0, d1;
    logic ok;
    wire scl, sda, host_pull, sda_oe, sda_out;
    wire [11:0] cur;
    int seed = 89753;
    int err_total = 0;
    int n_tests = 0;
    assign sda = !host_pull && (sda_oe ? sda_out : 1'b1);
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    charger_status_readback #(.DEVICE_ADDR(DEV)) DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_scl_in(scl),
        .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_input_rail_present(st[0]),
        .i_charge_phase(st[3:1]), .i_adapter_type(st[7:4]), .i_adapter_detect_done(st[8]),
        .i_input_current_optimizer_state(st[10:9]), .i_thermal_regulation_active(st[11]),
        .i_data_line_detect_active(st[12]), .i_battery_above_release_level(st[13]),
        .i_nonstd_current_sel(st[15:14]), .o_nominal_input_current_ma(cur));
    host_i2c_model #(.ADDR(DEV)) host (.o_scl(scl), .o_sda_pull(host_pull), .i_sda(sda));
    function automatic logic [7:0] exp_reg(logic [7:0] a);
        case (a)
            8'h1b: return {7'h00, st[0]};
            8'h1c: return {st[3:1], st[7:4], st[8]};
            8'h1d: return {st[10:9], 3'h0, st[11], st[12], st[13]};
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [11:0] exp_cur();
        case (st[7:4])
            4'h1: return charger_status_pkg::CURRENT_SDP_MA;
            4'h2, 4'h4: return charger_status_pkg::CURRENT_CDP_MA;
            4'h3: return charger_status_pkg::CURRENT_DCP_MA;
            4'h5: return charger_status_pkg::CURRENT_UNKNOWN_MA;
            4'h6: return st[15] ? (st[14] ? 12'h960 : 12'h834) : (st[14] ? 12'h7d0 : 12'h3e8);
            default: return 12'h000;
        endcase
    endfunction
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_cur(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic drive(input logic [15:0] val);
        @(posedge i_sys_clk);
        #2 st = val;
        repeat (3) @(posedge i_sys_clk);
    endtask
    // two-byte read also checks the pointer step to the next offset
    task automatic read_check(input logic [7:0] ptr);
        host.read2(ptr, d0, d1, ok);
        chk_flag("read_ack", 1'b1, ok);
        chk_byte("first_byte", exp_reg(ptr), d0);
        chk_byte("second_byte", exp_reg(ptr + 8'h01), d1);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge i_sys_clk);
        err_total++;
        $display("timeout");
        final_report();
    end
    initial begin
        repeat (10) @(posedge i_sys_clk);
        chk_cur("current_in_reset", 12'h000, cur);
        repeat (10) @(posedge i_sys_clk);
        #2 i_rst_n = 1'b1;
        repeat (6) @(posedge i_sys_clk);
        read_check(8'h1b);
        read_check(8'h1d);
        $display("test reset_values done");
        // every adapter, phase and optimizer code, then non-standard with each selector
        for (int i = 0; i < 20; i++) begin
            v = $random(seed);
            drive({i[1:0], v[13:11], i[1:0], v[8], (i > 15) ? 4'h6 : i[3:0], i[2:0], v[0]});
            chk_cur("nominal_current", exp_cur(), cur);
            read_check(8'h1b);
            read_check(8'h1d);
        end
        $display("test live_fields done");
        host.write1(8'h1c, 8'hff, ok);
        chk_flag("write_ack", 1'b1, ok);
        read_check(8'h1c);
        $display("test write_ignored done");
        host.probe(DEV ^ 7'h01, ok);
        chk_flag("foreign_address_ack", 1'b0, ok);
        read_check(8'h1c);
        $display("test foreign_address done");
        drive(16'h0030);
        #2 i_rst_n = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        chk_cur("current_mid_reset", 12'h000, cur);
        repeat (17) @(posedge i_sys_clk);
        #2 i_rst_n = 1'b1;
        repeat (6) @(posedge i_sys_clk);
        chk_cur("current_after_reset", charger_status_pkg::CURRENT_DCP_MA, cur);
        read_check(8'h1c);
        $display("test second_reset done");
        final_report();
    end
endmodule // tb
